// File: src/mpbd_pkg.sv
// constants for the microprocessor bus address decoder
// assumes a 100 MHz system clock from which the bus phases are derived
package mpbd_pkg;
  localparam int unsigned SYS_CLK_MHZ       = 100;
  localparam int unsigned XTAL_MHZ          = 4;
  localparam int unsigned MPU_MHZ           = 1;
  // system clock cycles per quarter of a processor cycle (4 MHz crystal tick)
  localparam int unsigned QUARTER_CYCLES    = SYS_CLK_MHZ / XTAL_MHZ;
  localparam logic [4:0]  QUARTER_LAST      = 5'(QUARTER_CYCLES - 1);
  // power-fail ride-through time, in microseconds
  localparam int unsigned PFAIL_TIME_US     = 1000;
  localparam int unsigned PFAIL_CYCLES      = PFAIL_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned PFAIL_W           = 24;

  // decode match patterns
  localparam logic [6:0]  SCRATCH_TOP       = 7'h00;
  localparam logic [5:0]  PORT_PANEL_TOP    = 6'h01;
  localparam logic [4:0]  REG_BLOCK_TOP     = 5'h01;
  localparam logic [3:0]  FW_TOP            = 4'hf;
  localparam logic [3:0]  EXT_FW_TOP        = 4'he;
  localparam int unsigned PANEL_SEL_BIT     = 2;
  localparam int unsigned DISK_SEL_BIT      = 6;
  localparam int unsigned BUFFER_SEL_BIT    = 12;
  localparam int unsigned BYTE_LANE_BIT     = 0;
  localparam logic [15:0] RESTART_ADDR      = 16'hfffe;

  localparam int unsigned NUM_TARGETS       = 9;
  localparam logic [7:0]  DATA_IDLE         = 8'h00;

  typedef enum logic [3:0] {
    MPBD_T_SCRATCH,
    MPBD_T_PORT,
    MPBD_T_PANEL,
    MPBD_T_XFER,
    MPBD_T_DISK,
    MPBD_T_BUF_HI,
    MPBD_T_BUF_LO,
    MPBD_T_FW,
    MPBD_T_EXT_FW,
    MPBD_T_NONE
  } mpbd_target_t;

  typedef enum logic [1:0] {
    MPBD_PF_IDLE,
    MPBD_PF_TIMING,
    MPBD_PF_RESTART
  } mpbd_pfail_t;
endpackage

// File: src/mpbd_decoder.sv
// microprocessor bus fabric: clock phases, address decode, strobes and control line routing
// assumes processor outputs arrive synchronous to clk; targets supply the read data that is sampled in phase two
`timescale 1ns/1ps

// Overview of operation
// (RULE1) Scratchpad for bits 15..9 zero, firmware for top nibble f, extended firmware for e.
// (RULE2) Bits 15..10 of 000001 select the port group when bit 2 is low and the panel when high.
// (RULE3) Bits 15..11 of 00001 pick transfer control when bit 6 is low, disk control when high.
// (RULE4) Bit 12 in the low region selects the data buffer, bit 0 choosing the high or low byte.
// (RULE5) Only the bits routed to a target are compared, so don't-care bits alias.
// (RULE6) Every select is gated by the valid-address strobe.
// (RULE7) Writes strobe at the fall of phase two and read data is driven only in phase two.
// (RULE8) The read/write line reads as read out of reset and steers load versus drive.
// (RULE9) The processor data-bus-enable follows the phase-two clock.
// (RULE10) Maskable interrupt requests pass to the processor, which vectors through fff8/fff9.
// (RULE11) The buffered supply low flag drives the non-maskable input, vectoring at fffc/fffd.
// (RULE12) The test unit must not raise halt in the last half of phase one.
// (RULE13) In single stepping the test unit drops halt for at least one full cycle.
// (RULE14) Two non-overlapping 1 MHz phases and 2x and 4x sync clocks come from the crystal rate.
// (RULE15) A power-fail interrupt starts a timer whose expiry signals a restart that polls ports.
// (RULE16) Under reset the address presented to the decode is forced to all ones at the top.
// (RULE17) At most one select is active per cycle and an unmapped address selects nothing.
module mpbd_decoder #(
  parameter int unsigned PFAIL_COUNT = mpbd_pkg::PFAIL_CYCLES
) (
  input  wire logic        clk,                    // 100 MHz system clock
  input  wire logic        sys_rst,                // power-on reset, async, active high
  input  wire logic [15:0] cpu_addr,               // processor address bus
  input  wire logic        valid_address_strobe,   // processor valid address
  input  wire logic        cpu_read,               // processor read/write, high = read
  input  wire logic [7:0]  cpu_wdata,              // processor write data
  input  wire logic [7:0]  tgt_rdata,              // read data from the selected target
  input  wire logic        irq_in,                 // or of block interrupt requests
  input  wire logic        ac_low,                 // supply ac low, active high
  input  wire logic        halt_in,                // halt from the test unit
  output logic             phase_one_clock,        // processor phase 1
  output logic             phase_two_clock,        // processor phase 2
  output logic             double_rate_sync_clock, // 2x sync clock
  output logic             quad_rate_sync_clock,   // 4x sync clock
  output logic             cpu_dbe,                // processor data bus enable
  output logic             cpu_reset,              // processor reset, high = reset
  output logic             cpu_irq,                // processor maskable interrupt
  output logic             cpu_nmi,                // processor non-maskable interrupt
  output logic             cpu_halt,               // processor halt
  output logic [15:0]      dec_addr,               // address as seen by the decode
  output logic [mpbd_pkg::NUM_TARGETS-1:0] sel,    // one-hot block selects
  output logic             tgt_read,               // read/write to targets, high = read
  output logic [mpbd_pkg::NUM_TARGETS-1:0] wr_strobe, // one-cycle write strobe per target
  output logic [7:0]       tgt_wdata,              // write data to targets
  output logic [7:0]       cpu_rdata,              // read data to processor
  output logic             cpu_rdata_oe_n,         // read data drive enable, low = drive
  output logic             restart_req,            // one-cycle pulse: transient power loss
  output logic             pfail_active            // power-fail timer running
);
  import mpbd_pkg::*;

  typedef struct packed {
    logic [4:0]             tick;
    logic [1:0]             quarter;
    logic                   ph1;
    logic                   ph2;
    logic                   x2;
    logic                   x4;
    logic                   dbe;
    logic                   rst_out;
    logic                   irq;
    logic                   nmi;
    logic                   halt;
    logic [15:0]            addr;
    logic [NUM_TARGETS-1:0] sel;
    logic                   rd;
    logic [NUM_TARGETS-1:0] wstb;
    logic [7:0]             wdata;
    logic [7:0]             rdata;
    logic                   rdata_oe_n;
    mpbd_pfail_t            pf_state;
    logic [PFAIL_W-1:0]     pf_count;
    logic                   restart;
    logic                   pf_busy;
  } mpbd_state_t;

  mpbd_state_t st;
  mpbd_state_t next_st;
  mpbd_target_t tgt;
  logic [15:0]  a;
  logic         ph2_fall;
  logic         quarter_end;
  logic         scratch_hit;
  logic         fw_hit;
  logic         ext_fw_hit;
  logic         port_panel_hit;
  logic         reg_block_hit;
  logic         buffer_hit;
  logic [NUM_TARGETS-1:0] sel_hit;

  // (RULE16) restart vector forcing
  // under reset the top address lines read high, so the decode sees the restart vector
  assign a = sys_rst ? RESTART_ADDR : cpu_addr;

  // (RULE5) partial decode only
  // each window compares just the bits routed to it; the rest alias on purpose
  // (RULE1) memory region windows
  assign scratch_hit = (a[15:9] == SCRATCH_TOP);
  assign fw_hit = (a[15:12] == FW_TOP);
  assign ext_fw_hit = (a[15:12] == EXT_FW_TOP);
  // (RULE2) port and panel window
  assign port_panel_hit = (a[15:10] == PORT_PANEL_TOP);
  // (RULE3) register block window
  assign reg_block_hit = (a[15:11] == REG_BLOCK_TOP);
  // (RULE4) buffer window
  // bit 13 is not routed to the buffer, so both halves alias
  assign buffer_hit = (a[15:14] == 2'b00) && a[BUFFER_SEL_BIT];

  // the windows are disjoint, so the order of the tests carries no priority
  always_comb begin
    tgt = MPBD_T_NONE;
    if (scratch_hit) begin
      tgt = MPBD_T_SCRATCH;
    end else if (fw_hit) begin
      tgt = MPBD_T_FW;
    end else if (ext_fw_hit) begin
      tgt = MPBD_T_EXT_FW;
    end else if (port_panel_hit) begin
      // (RULE2) port or panel
      tgt = a[PANEL_SEL_BIT] ? MPBD_T_PANEL : MPBD_T_PORT;
    end else if (reg_block_hit) begin
      // (RULE3) transfer or disk
      tgt = a[DISK_SEL_BIT] ? MPBD_T_DISK : MPBD_T_XFER;
    end else if (buffer_hit) begin
      // (RULE4) buffer byte lane
      tgt = a[BYTE_LANE_BIT] ? MPBD_T_BUF_LO : MPBD_T_BUF_HI;
    end
  end

  // (RULE6) valid-gated selects
  // (RULE17) one enum index per target keeps the vector one-hot or empty
  for (genvar g = 0; g < NUM_TARGETS; g++) begin : gen_sel
    assign sel_hit[g] = valid_address_strobe && (tgt == mpbd_target_t'(g));
  end

  assign quarter_end = (st.tick == QUARTER_LAST);
  assign ph2_fall = st.ph2 && (st.quarter == 2'd3) && quarter_end;

  always_comb begin
    next_st = st;
    next_st.restart = 1'b0;
    // (RULE14) quarter-cycle phase generator
    if (quarter_end) begin
      next_st.tick = 5'd0;
      next_st.quarter = 2'(st.quarter + 2'd1);
    end else begin
      next_st.tick = 5'(st.tick + 5'd1);
    end
    // one dead tick at each phase edge keeps the phases from overlapping
    next_st.ph1 = !next_st.quarter[1] && (next_st.tick != 5'd0 || next_st.quarter[0]);
    next_st.ph2 = next_st.quarter[1] && (next_st.tick != 5'd0 || next_st.quarter[0]);
    next_st.x2 = !next_st.quarter[0];
    next_st.x4 = next_st.tick < 5'(QUARTER_CYCLES / 2);
    // (RULE9) bus enable follows phase two
    next_st.dbe = next_st.ph2;
    next_st.rst_out = 1'b0;
    // (RULE10) maskable request routing
    next_st.irq = irq_in;
    // (RULE11) supply low to nmi
    next_st.nmi = ac_low;
    next_st.halt = halt_in;
    next_st.addr = a;
    // (RULE6) gated selects registered
    next_st.sel = sel_hit;
    // (RULE8) direction to targets
    next_st.rd = cpu_read;
    next_st.wdata = cpu_wdata;
    // (RULE7) write at phase two fall
    next_st.wstb = '0;
    if (ph2_fall && !cpu_read) begin
      next_st.wstb = next_st.sel;
    end
    // (RULE7) read data only in phase two
    if (next_st.ph2 && cpu_read && (next_st.sel != '0)) begin
      next_st.rdata = tgt_rdata;
      next_st.rdata_oe_n = 1'b0;
    end else begin
      next_st.rdata = DATA_IDLE;
      next_st.rdata_oe_n = 1'b1;
    end
    // (RULE15) power-fail ride-through timer
    case (st.pf_state)
      MPBD_PF_IDLE: begin
        next_st.pf_count = '0;
        if (ac_low) begin
          next_st.pf_state = MPBD_PF_TIMING;
        end
      end
      MPBD_PF_TIMING: begin
        if (st.pf_count >= PFAIL_W'(PFAIL_COUNT - 1)) begin
          next_st.pf_state = MPBD_PF_RESTART;
          next_st.restart = 1'b1;
        end else begin
          next_st.pf_count = PFAIL_W'(st.pf_count + 1'b1);
        end
      end
      MPBD_PF_RESTART: begin
        // wait for the supply flag to clear before arming again
        if (!ac_low) begin
          next_st.pf_state = MPBD_PF_IDLE;
        end
      end
      default: begin
        next_st.pf_state = MPBD_PF_IDLE;
      end
    endcase
    // timer-running flag kept in its own flop so the output is registered
    next_st.pf_busy = (next_st.pf_state == MPBD_PF_TIMING);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.rst_out <= 1'b1;
      // (RULE8) read state out of reset
      st.rd <= 1'b1;
      st.rdata_oe_n <= 1'b1;
      st.addr <= RESTART_ADDR;
      st.pf_state <= MPBD_PF_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign phase_one_clock = st.ph1;
  assign phase_two_clock = st.ph2;
  assign double_rate_sync_clock = st.x2;
  assign quad_rate_sync_clock = st.x4;
  assign cpu_dbe = st.dbe;
  assign cpu_reset = st.rst_out;
  assign cpu_irq = st.irq;
  assign cpu_nmi = st.nmi;
  // halt timing against phase one is the test unit's duty; passed through registered
  assign cpu_halt = st.halt;
  assign dec_addr = st.addr;
  assign sel = st.sel;
  assign tgt_read = st.rd;
  assign wr_strobe = st.wstb;
  assign tgt_wdata = st.wdata;
  assign cpu_rdata = st.rdata;
  assign cpu_rdata_oe_n = st.rdata_oe_n;
  assign restart_req = st.restart;
  assign pfail_active = st.pf_busy;
endmodule

// File: test/mpbd_checker.sv
// assertions on the bus decoder top ports
// bound to every mpbd_decoder; reset async active high
`timescale 1ns/1ps
module mpbd_checker #(
  parameter int unsigned PFAIL_COUNT = 20
) (
  input wire logic                        clk,                  // clock
  input wire logic                        sys_rst,              // reset
  input wire logic [15:0]                 cpu_addr,             // address
  input wire logic                        valid_address_strobe, // valid
  input wire logic                        phase_one_clock,      // phase 1
  input wire logic                        phase_two_clock,      // phase 2
  input wire logic                        cpu_dbe,              // bus enable
  input wire logic [mpbd_pkg::NUM_TARGETS-1:0] sel,             // selects
  input wire logic                        tgt_read,             // direction
  input wire logic [mpbd_pkg::NUM_TARGETS-1:0] wr_strobe,       // strobes
  input wire logic                        cpu_rdata_oe_n,       // drive, low
  input wire logic                        restart_req,          // restart pulse
  input wire logic                        pfail_active          // timer running
);
  import mpbd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence ph2_end;
    phase_two_clock ##1 !phase_two_clock;
  endsequence
  wire v = valid_address_strobe;
  one_hot_a: assert property ($onehot0(sel))
    else $error("more than one select");
  scratch_sel_a: assert property (v && cpu_addr[15:9] == SCRATCH_TOP |=> sel == 9'h001)
    else $error("scratch select wrong");
  fw_sel_a: assert property (v && cpu_addr[15:12] == FW_TOP |=> sel == 9'h080)
    else $error("firmware select wrong");
  ext_fw_a: assert property (v && cpu_addr[15:12] == EXT_FW_TOP |=> sel == 9'h100)
    else $error("extended firmware select wrong");
  port_panel_a: assert property (v && cpu_addr[15:10] == PORT_PANEL_TOP |=>
    sel == ($past(cpu_addr[2]) ? 9'h004 : 9'h002)) else $error("port or panel select wrong");
  reg_block_a: assert property (v && cpu_addr[15:11] == REG_BLOCK_TOP |=>
    sel == ($past(cpu_addr[6]) ? 9'h010 : 9'h008)) else $error("register block select wrong");
  buf_byte_a: assert property (v && cpu_addr[15:14] == 2'h0 && cpu_addr[12] |=>
    sel == ($past(cpu_addr[0]) ? 9'h040 : 9'h020)) else $error("buffer byte select wrong");
  no_valid_a: assert property (!v |=> sel == 9'h000)
    else $error("select without valid address");
  phase_excl_a: assert property (!(phase_one_clock && phase_two_clock))
    else $error("phases overlap");
  dbe_follow_a: assert property (cpu_dbe == phase_two_clock)
    else $error("bus enable not phase two");
  read_drive_a: assert property (!cpu_rdata_oe_n |->
    phase_two_clock && tgt_read && sel != 0)
    else $error("read data driven outside phase two read");
  strobe_fire_a: assert property (ph2_end |-> wr_strobe == (tgt_read ? '0 : sel))
    else $error("write strobe missing at phase two fall");
  restart_pulse_a: assert property (restart_req |->
    $past(pfail_active) && !pfail_active) else $error("restart outside timer expiry");
  write_edge_a: assert property (wr_strobe != 0 |-> $fell(phase_two_clock)
    && wr_strobe == sel && !tgt_read) else $error("write strobe misplaced");
  cover property (ph2_end ##0 wr_strobe != 0);
endmodule

bind mpbd_decoder mpbd_checker #(.PFAIL_COUNT(PFAIL_COUNT)) mpbd_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr), .valid_address_strobe(valid_address_strobe),
  .phase_one_clock(phase_one_clock), .phase_two_clock(phase_two_clock), .cpu_dbe(cpu_dbe),
  .sel(sel), .tgt_read(tgt_read), .wr_strobe(wr_strobe), .cpu_rdata_oe_n(cpu_rdata_oe_n),
  .restart_req(restart_req), .pfail_active(pfail_active));

// File: test/mpbd_cpu_model.sv
// processor side of the bus: address, direction, write data
// the bench raises go for the length of a bus cycle
`timescale 1ns/1ps
module mpbd_cpu_model (
  input  wire logic        clk,                  // clock
  input  wire logic        go,                   // bus cycle active
  input  wire logic [15:0] a,                    // address wanted
  input  wire logic        rd,                   // high = read
  input  wire logic [7:0]  wd,                   // write data wanted
  output logic [15:0]      cpu_addr,             // address bus
  output logic             valid_address_strobe, // address valid
  output logic             cpu_read,             // high = read
  output logic [7:0]       cpu_wdata             // write data
);
  // idle lines change every cycle so stale values cannot pass
  logic [15:0] idle = 16'h5a5a;
  always @(negedge clk) idle <= ~idle + 16'h0001;
  assign cpu_addr = go ? a : idle;
  assign valid_address_strobe = go;
  assign cpu_read = go ? rd : 1'b1;
  assign cpu_wdata = (go && !rd) ? wd : idle[7:0];
endmodule

// File: test/mpbd_decoder_tb.sv
// self-checking bench for the bus decoder with a processor model
// power-fail count shortened to PF cycles
`timescale 1ns/1ps
module mpbd_decoder_tb;
  import mpbd_pkg::*;
  localparam int unsigned PF = 20;
  logic clk = 0, sys_rst = 1, go = 0, rd = 1, irq_in = 0, ac_low = 0, halt_in = 0;
  logic [15:0] a = 16'h0000, cpu_addr, dec_addr;
  logic [7:0] wd = 8'h00, tgt_rdata = 8'h00, cpu_wdata, tgt_wdata, cpu_rdata;
  logic valid_address_strobe, cpu_read, phase_one_clock, phase_two_clock, cpu_dbe;
  logic double_rate_sync_clock, quad_rate_sync_clock, cpu_reset, cpu_irq, cpu_nmi, cpu_halt;
  logic tgt_read, cpu_rdata_oe_n, restart_req, pfail_active;
  logic [8:0] sel, wr_strobe;
  int fails = 0, n_tests = 0;
  logic [15:0] adr [15] = '{16'h0000, 16'h01ff, 16'h0200, 16'h0400, 16'h07fb, 16'h0404,
    16'h0800, 16'h0fbf, 16'h0840, 16'h1000, 16'h37ff, 16'he123, 16'hffff, 16'h8000, 16'h2000};
  logic [8:0] esel [15] = '{9'h001, 9'h001, 9'h000, 9'h002, 9'h002, 9'h004,
    9'h008, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100, 9'h080, 9'h000, 9'h000};
  always #5 clk = ~clk;
  mpbd_cpu_model mpbd_cpu_model_inst (.clk, .go, .a, .rd, .wd, .cpu_addr,
    .valid_address_strobe, .cpu_read, .cpu_wdata);
  mpbd_decoder #(.PFAIL_COUNT(PF)) mpbd_decoder_inst (.clk, .sys_rst, .cpu_addr,
    .valid_address_strobe, .cpu_read, .cpu_wdata, .tgt_rdata, .irq_in, .ac_low, .halt_in,
    .phase_one_clock, .phase_two_clock, .double_rate_sync_clock, .quad_rate_sync_clock,
    .cpu_dbe, .cpu_reset, .cpu_irq, .cpu_nmi, .cpu_halt, .dec_addr, .sel, .tgt_read,
    .wr_strobe, .tgt_wdata, .cpu_rdata, .cpu_rdata_oe_n, .restart_req, .pfail_active);
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task t_reset;
    chk("dec_addr", dec_addr, RESTART_ADDR);
    chk("cpu_reset", cpu_reset, 1);
    chk("tgt_read", tgt_read, 1);
    chk("oe_n", cpu_rdata_oe_n, 1);
  endtask
  task t_decode;
    for (int i = 0; i < 15; i++) begin
      go = 1;
      a = adr[i];
      cyc(1);
      chk("sel", sel, esel[i]);
    end
    go = 0;
    cyc(1);
    chk("sel idle", sel, 0);
  endtask
  task t_write;
    go = 1;
    a = 16'h0841;
    rd = 0;
    wd = 8'ha5;
    for (int k = 0; k < 200 && wr_strobe === 9'h000; k++) cyc(1);
    chk("wr_strobe", wr_strobe, 9'h010);
    chk("tgt_wdata", tgt_wdata, 8'ha5);
    chk("tgt_read wr", tgt_read, 0);
    cyc(1);
    chk("wr pulse", wr_strobe, 0);
    rd = 1;
  endtask
  task t_read;
    a = 16'h1001;
    tgt_rdata = 8'h3c;
    for (int k = 0; k < 200 && cpu_rdata_oe_n !== 1'b0; k++) cyc(1);
    chk("rdata", cpu_rdata, 8'h3c);
    chk("ph2 read", phase_two_clock, 1);
    for (int k = 0; k < 200 && phase_one_clock !== 1'b1; k++) cyc(1);
    chk("oe ph1", cpu_rdata_oe_n, 1);
    go = 0;
  endtask
  task t_clocks;
    int h1, h2, h4, h8, ov;
    {h1, h2, h4, h8, ov} = '0;
    repeat (100) begin
      cyc(1);
      h1 += phase_one_clock;
      h2 += phase_two_clock;
      h4 += double_rate_sync_clock;
      h8 += quad_rate_sync_clock;
      ov += (phase_one_clock & phase_two_clock) | (cpu_dbe ^ phase_two_clock);
    end
    chk("ph1 high", 16'(h1), 16'(2 * QUARTER_CYCLES - 1));
    chk("ph2 high", 16'(h2), 16'(2 * QUARTER_CYCLES - 1));
    chk("2x high", 16'(h4), 16'(2 * QUARTER_CYCLES));
    chk("4x high", 16'(h8), 16'(4 * (QUARTER_CYCLES / 2)));
    chk("overlap", 16'(ov), 0);
  endtask
  task t_lines;
    for (int k = 0; k < 200 && phase_two_clock !== 1'b1; k++) cyc(1);
    irq_in = 1;
    halt_in = 1;
    cyc(1);
    chk("irq", cpu_irq, 1);
    chk("halt", cpu_halt, 1);
    irq_in = 0;
    halt_in = 0;
    cyc(100);
    chk("irq off", cpu_irq, 0);
    chk("halt off", cpu_halt, 0);
  endtask
  task t_pfail;
    int n;
    ac_low = 1;
    cyc(1);
    chk("nmi", cpu_nmi, 1);
    chk("pfail busy", pfail_active, 1);
    for (n = 0; n < 100 && restart_req !== 1'b1; n++) cyc(1);
    chk("restart time", 16'(n), 16'(PF));
    cyc(1);
    chk("restart pulse", restart_req, 0);
    ac_low = 0;
    cyc(2);
    chk("pfail idle", pfail_active, 0);
    chk("nmi off", cpu_nmi, 0);
  endtask
  task t_rerst;
    go = 1;
    a = 16'h0000;
    sys_rst = 1;
    cyc(3);
    t_reset;
    sys_rst = 0;
    cyc(2);
    chk("sel resume", sel, 9'h001);
    chk("cpu_reset off", cpu_reset, 0);
    chk("dec_addr resume", dec_addr, 16'h0000);
    go = 0;
  endtask
  initial begin
    cyc(19);
    t_reset;
    cyc(1);
    sys_rst = 0;
    cyc(2);
    t_decode;
    t_write;
    t_read;
    t_clocks;
    t_lines;
    t_pfail;
    t_rerst;
    test_done;
  end
  initial begin
    #500000;
    fails++;
    test_done;
  end
endmodule
